// ---- verilog/aspm_cfg.svh ----
// aspm_cfg.svh: timing counts and edge positions of the serial converter frame
// assumes both ends run on one 100 MHz core clock
`ifndef ASPM_CFG_SVH
`define ASPM_CFG_SVH
// core clock period, ns
`define ASPM_CLK_NS 10
// result and word widths
`define ASPM_RES_W 12
`define ASPM_WORD_W 16
// edge positions and count limit inside a frame
`define ASPM_SHDN_FIRST_FALL 5'h02
// shutdown window closes once the tenth fall has been seen
`define ASPM_SHDN_END_FALL 5'h0A
`define ASPM_WORD_FALLS 5'h10
`define ASPM_TRACK_RISE 5'h0D
`define ASPM_CNT_SAT 5'h1F
// host side frame shape
`define ASPM_FRAME_FALLS 5'h14
`define ASPM_HOST_SHDN_FALL 5'h04
`define ASPM_SAMPLE_FIRST 5'h05
// serial clock half period in core cycles (80 ns period)
`define ASPM_SCLK_HALF 4
// quiet interval between frames, ns
`define ASPM_QUIET_NS 50
`endif

// ---- verilog/aspm_pkg.sv ----
// aspm_pkg: state and mode types shared by both ends of the converter link
// assumes aspm_cfg.svh supplies the numeric constants
package aspm_pkg;
	// power mode of the converter, one-hot
	typedef enum logic [1:0] {
		ASPM_MODE_NORMAL = 2'h1,
		ASPM_MODE_SHDN = 2'h2
	} aspm_mode_t;
	// host frame sequencer, one-hot
	typedef enum logic [3:0] {
		ASPM_H_IDLE = 4'h1,
		ASPM_H_HIGH = 4'h2,
		ASPM_H_LOW = 4'h4,
		ASPM_H_QUIET = 4'h8
	} aspm_hst_t;
endpackage : aspm_pkg

// ---- verilog/aspm_link_if.sv ----
// aspm_link_if: three-wire link between host and converter
// assumes the bench ties both modports to one instance
`timescale 1ns/1ps
interface aspm_link_if;
	logic frame_sel_n; // active-low frame select, host drives
	logic sclk; // serial clock, host drives
	logic sdo; // converter data bit
	logic sdo_oe; // converter drives data line while high
	wire serial_result_out; // resolved line, floating reads low
	wire line_floating; // high while nobody drives the data line
	assign serial_result_out = sdo_oe & sdo;
	assign line_floating = ~sdo_oe;
	modport device (input frame_sel_n, input sclk, output sdo, output sdo_oe);
	modport host (output frame_sel_n, output sclk, input serial_result_out,
		input line_floating);
endinterface : aspm_link_if

// ---- verilog/aspm_device.sv ----
// aspm_device: converter end of the link; frames, power mode and result shifting
// assumes frame select and serial clock arrive asynchronously and are synchronised here
// Overview of operation
// RULE1: frame select fall starts frame, normal mode
// RULE2: rise after falls two..nine: shutdown, abort, float
// RULE3: rise before second fall keeps mode
// RULE4: rise after ten, before sixteen: abort, normal
// RULE5: host holds select past tenth for normal
// RULE6: shutdown holds until next select fall
// RULE7: sixteen clocks read word, then float
// RULE8: host raises select before next frame
// RULE9: shutdown powers down conversion circuitry
// RULE10: frame from shutdown is dummy power-up
// RULE11: power-up frame aborted early returns shutdown
// RULE12: powered up after sixteen-clock frame
// RULE13: host keeps quiet interval after dummy
// RULE14: start mode undefined; host runs dummy
// RULE15: host uses twenty-clock frames
// RULE16: three zeros, twelve bits, msb first; code sends four zeros (one at select fall, three at falls 1..3)
// RULE17: output driven at fall; track at rise 13
// RULE18: count falls per frame, decide at rise
`timescale 1ns/1ps
`include "aspm_cfg.svh"
module aspm_device #(
	parameter logic START_IN_SHDN = 1'b1, // power mode after reset
	parameter int RES_W = `ASPM_RES_W // result width
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// link to host
	aspm_link_if.device link,
	// converter core side
	input wire logic [RES_W-1:0] i_sample,
	// status
	output logic o_in_shutdown,
	output logic o_tracking,
	output logic o_powered_up,
	output logic o_frame_done,
	output logic o_frame_valid
);
	localparam int WORD_W = `ASPM_WORD_W; // shifted word width

	// synchronisers, index 0 is the first stage
	logic [2:0] sclk_sync_ff; // serial clock history
	logic [2:0] cs_sync_ff; // frame select history
	// frame state
	logic frame_open_ff; // select low since a counted fall
	logic [4:0] fall_cnt_ff; // falling clock edges in frame
	logic [4:0] rise_cnt_ff; // rising clock edges in frame
	logic from_shdn_ff; // frame started from shutdown or cold
	logic [WORD_W-1:0] shift_ff; // outgoing word
	logic sdo_ff; // data bit on the line
	logic sdo_oe_ff; // data line driven
	aspm_pkg::aspm_mode_t mode_ff; // present power mode
	logic powered_ff; // conversion circuitry fully up
	logic tracking_ff; // track (1) or hold (0)
	logic done_ff; // word complete pulse
	logic valid_ff; // last complete word usable

	// edge decode from the settled stages only
	wire sclk_fall = sclk_sync_ff[2] & ~sclk_sync_ff[1];
	wire sclk_rise = ~sclk_sync_ff[2] & sclk_sync_ff[1];
	wire cs_fall = cs_sync_ff[2] & ~cs_sync_ff[1];
	wire cs_rise = ~cs_sync_ff[2] & cs_sync_ff[1];
	// counters advance only inside an open frame, saturating
	wire fall_tick = frame_open_ff & sclk_fall & (fall_cnt_ff != `ASPM_CNT_SAT);
	wire rise_tick = frame_open_ff & sclk_rise & (rise_cnt_ff != `ASPM_CNT_SAT);
	wire [4:0] nxt_fall_cnt = 5'(fall_cnt_ff + 5'h01);
	wire [4:0] nxt_rise_cnt = 5'(rise_cnt_ff + 5'h01);
	// sixteenth fall closes the word
	wire word_end = fall_tick & (nxt_fall_cnt == `ASPM_WORD_FALLS);
	// falls one..fifteen shift the next bit out
	wire bit_tick = fall_tick & (nxt_fall_cnt < `ASPM_WORD_FALLS);
	// rise decisions by falls seen so far
	wire frame_rise = cs_rise & frame_open_ff;
	wire early_rise = fall_cnt_ff < `ASPM_SHDN_FIRST_FALL;
	// a rise after the tenth fall keeps normal mode, so the bound is exclusive
	wire shdn_window = ~early_rise & (fall_cnt_ff < `ASPM_SHDN_END_FALL);
	wire word_cut = frame_rise & (fall_cnt_ff < `ASPM_WORD_FALLS);
	wire go_shdn = frame_rise & ((early_rise & from_shdn_ff) | shdn_window);
	wire stay_mode = frame_rise & early_rise & ~from_shdn_ff;
	// next power mode
	wire aspm_pkg::aspm_mode_t nxt_mode =
		cs_fall ? aspm_pkg::ASPM_MODE_NORMAL : // see RULE1
		go_shdn ? aspm_pkg::ASPM_MODE_SHDN : // see RULE2 see RULE11
		stay_mode ? mode_ff : // see RULE3
		mode_ff; // see RULE4 see RULE6
	// word from core, leading bits zero
	wire [WORD_W-1:0] load_word = {{(WORD_W - RES_W){1'b0}}, i_sample};
	// frame counts as power-up if shutdown or not powered up
	wire nxt_from_shdn = (mode_ff == aspm_pkg::ASPM_MODE_SHDN) | ~powered_ff;

	// two-stage synchronisers plus one edge stage
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sclk_sync_ff <= 3'h7;
			cs_sync_ff <= 3'h7;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
			cs_sync_ff <= {cs_sync_ff[1:0], link.frame_sel_n};
		end
	end

	// frame open from select fall to select rise
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			frame_open_ff <= 1'b0;
		end else if (cs_fall) begin
			frame_open_ff <= 1'b1; // see RULE18
		end else if (cs_rise) begin
			frame_open_ff <= 1'b0;
		end
	end

	// edge counters restart at every select fall
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			fall_cnt_ff <= 5'h00;
			rise_cnt_ff <= 5'h00;
		end else if (cs_fall) begin
			fall_cnt_ff <= 5'h00; // see RULE18
			rise_cnt_ff <= 5'h00;
		end else begin
			if (fall_tick) begin
				fall_cnt_ff <= nxt_fall_cnt; // see RULE18
			end
			if (rise_tick) begin
				rise_cnt_ff <= nxt_rise_cnt;
			end
		end
	end

	// power mode register
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			mode_ff <= START_IN_SHDN ? aspm_pkg::ASPM_MODE_SHDN :
				aspm_pkg::ASPM_MODE_NORMAL; // see RULE14
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// power-up tracking: cold or shutdown frames are dummies
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			powered_ff <= ~START_IN_SHDN;
			from_shdn_ff <= 1'b1;
		end else begin
			if (cs_fall) begin
				from_shdn_ff <= nxt_from_shdn; // see RULE10
			end
			if (go_shdn) begin
				powered_ff <= 1'b0; // see RULE9
			end else if (word_end) begin
				powered_ff <= 1'b1; // see RULE12
			end
		end
	end

	// outgoing word shifter
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			shift_ff <= '0;
			sdo_ff <= 1'b0;
		end else if (cs_fall) begin
			shift_ff <= load_word; // see RULE16
			sdo_ff <= 1'b0; // extra zero before first fall
		end else if (bit_tick) begin
			sdo_ff <= shift_ff[WORD_W-2]; // see RULE16
			shift_ff <= {shift_ff[WORD_W-2:0], 1'b0};
		end
	end

	// data line drive window
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sdo_oe_ff <= 1'b0;
		end else if (cs_fall) begin
			sdo_oe_ff <= 1'b1; // see RULE17
		end else if (word_end | word_cut) begin
			sdo_oe_ff <= 1'b0; // see RULE7 see RULE2 see RULE4
		end
	end

	// track and hold state
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			tracking_ff <= 1'b1;
		end else if (cs_fall) begin
			tracking_ff <= 1'b0; // sample held at select fall
		end else if (rise_tick & (nxt_rise_cnt == `ASPM_TRACK_RISE)) begin
			tracking_ff <= 1'b1; // see RULE17
		end else if (frame_rise) begin
			tracking_ff <= 1'b1; // aborted conversion releases hold
		end
	end

	// completion pulse and usability of the finished word
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			done_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			done_ff <= word_end; // see RULE7
			if (word_end) begin
				valid_ff <= ~from_shdn_ff; // see RULE10
			end
		end
	end

	// outputs straight from flip-flops
	assign link.sdo = sdo_ff;
	assign link.sdo_oe = sdo_oe_ff;
	assign o_in_shutdown = mode_ff[1]; // see RULE9
	assign o_tracking = tracking_ff;
	assign o_powered_up = powered_ff;
	assign o_frame_done = done_ff;
	assign o_frame_valid = valid_ff;
endmodule : aspm_device

// ---- verilog/aspm_host.sv ----
// aspm_host: link master; makes serial clock and frame select, collects results
// assumes the converter end follows the link protocol; data line read via two flops
`timescale 1ns/1ps
`include "aspm_cfg.svh"
module aspm_host #(
	parameter int RES_W = `ASPM_RES_W, // result width
	parameter int SCLK_HALF = `ASPM_SCLK_HALF // core cycles per clock half
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// link to converter
	aspm_link_if.host link,
	// command side
	input wire logic i_cmd_valid,
	input wire logic i_cmd_shdn,
	output logic o_cmd_ready,
	// result side
	output logic [RES_W-1:0] o_result,
	output logic o_result_valid,
	output logic o_result_dummy
);
	localparam int QUIET_CYC_I = (`ASPM_QUIET_NS + `ASPM_CLK_NS - 1) / `ASPM_CLK_NS;
	localparam logic [7:0] QUIET_CYC = 8'(QUIET_CYC_I < 1 ? 1 : QUIET_CYC_I);
	localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

	aspm_pkg::aspm_hst_t st_ff; // sequencer state
	logic [7:0] tmr_ff; // half period and quiet timer
	logic [4:0] fall_cnt_ff; // falls made in this frame
	logic shdn_ff; // present frame enters shutdown
	logic maybe_down_ff; // converter may not be powered
	logic dummy_ff; // present frame is a dummy
	logic cs_n_ff; // frame select drive
	logic sclk_ff; // serial clock drive
	logic [1:0] sdi_sync_ff; // data line synchroniser
	logic [RES_W-1:0] res_sh_ff; // incoming result bits
	logic [RES_W-1:0] result_ff; // last full result
	logic res_valid_ff; // result pulse
	logic res_dummy_ff; // result came from power-up frame
	logic ready_ff; // can take a command

	// timer decode and edge positions
	wire tmr_done = (st_ff == aspm_pkg::ASPM_H_QUIET) ? (tmr_ff == QUIET_CYC) :
		(tmr_ff == HALF_LAST);
	wire [4:0] nxt_fall_cnt = 5'(fall_cnt_ff + 5'h01);
	wire take_bit = (nxt_fall_cnt >= `ASPM_SAMPLE_FIRST) &
		(nxt_fall_cnt <= `ASPM_WORD_FALLS);
	wire end_frame = shdn_ff ? (fall_cnt_ff == `ASPM_HOST_SHDN_FALL) :
		(fall_cnt_ff == `ASPM_FRAME_FALLS);
	wire start = (st_ff == aspm_pkg::ASPM_H_IDLE) & i_cmd_valid;

	// data line synchroniser
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sdi_sync_ff <= 2'h0;
		end else begin
			sdi_sync_ff <= {sdi_sync_ff[0], link.serial_result_out};
		end
	end

	// timer restarts on every state step
	always_ff @(posedge i_core_clk) begin
		if (i_srst | start | (tmr_done & (st_ff != aspm_pkg::ASPM_H_IDLE))) begin
			tmr_ff <= 8'h00;
		end else begin
			tmr_ff <= 8'(tmr_ff + 8'h01);
		end
	end

	// frame sequencer
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_ff <= aspm_pkg::ASPM_H_IDLE;
			cs_n_ff <= 1'b1;
			sclk_ff <= 1'b1;
			fall_cnt_ff <= 5'h00;
		end else begin
			unique case (st_ff)
				aspm_pkg::ASPM_H_IDLE: begin
					if (start) begin
						cs_n_ff <= 1'b0; // see RULE8
						fall_cnt_ff <= 5'h00;
						st_ff <= aspm_pkg::ASPM_H_HIGH;
					end
				end
				aspm_pkg::ASPM_H_HIGH: begin
					if (tmr_done) begin
						sclk_ff <= 1'b0;
						fall_cnt_ff <= nxt_fall_cnt;
						st_ff <= aspm_pkg::ASPM_H_LOW;
					end
				end
				aspm_pkg::ASPM_H_LOW: begin
					if (tmr_done) begin
						sclk_ff <= 1'b1;
						if (end_frame) begin
							cs_n_ff <= 1'b1; // see RULE5 see RULE15 see RULE2
							st_ff <= aspm_pkg::ASPM_H_QUIET;
						end else begin
							st_ff <= aspm_pkg::ASPM_H_HIGH;
						end
					end
				end
				aspm_pkg::ASPM_H_QUIET: begin
					if (tmr_done) begin
						st_ff <= aspm_pkg::ASPM_H_IDLE; // see RULE13
					end
				end
			endcase
		end
	end

	// command capture and power-up bookkeeping
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			shdn_ff <= 1'b0;
			dummy_ff <= 1'b1;
			maybe_down_ff <= 1'b1; // see RULE14
		end else if (start) begin
			shdn_ff <= i_cmd_shdn;
			dummy_ff <= maybe_down_ff; // see RULE10
		end else if ((st_ff == aspm_pkg::ASPM_H_LOW) & tmr_done & end_frame) begin
			maybe_down_ff <= shdn_ff;
		end
	end

	// sample data at own falling edges, one bit behind the converter
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			res_sh_ff <= '0;
		end else if ((st_ff == aspm_pkg::ASPM_H_HIGH) & tmr_done & take_bit) begin
			res_sh_ff <= {res_sh_ff[RES_W-2:0], sdi_sync_ff[1]}; // see RULE16
		end
	end

	// result hand-off at end of quiet interval
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			result_ff <= '0;
			res_valid_ff <= 1'b0;
			res_dummy_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			res_valid_ff <= 1'b0;
			ready_ff <= (st_ff == aspm_pkg::ASPM_H_IDLE) & ~start;
			if ((st_ff == aspm_pkg::ASPM_H_QUIET) & tmr_done) begin
				ready_ff <= 1'b1;
				if (~shdn_ff) begin
					result_ff <= res_sh_ff;
					res_valid_ff <= 1'b1;
					res_dummy_ff <= dummy_ff;
				end
			end
		end
	end

	assign link.frame_sel_n = cs_n_ff;
	assign link.sclk = sclk_ff;
	assign o_cmd_ready = ready_ff;
	assign o_result = result_ff;
	assign o_result_valid = res_valid_ff;
	assign o_result_dummy = res_dummy_ff;
endmodule : aspm_host

// ---- sim/aspm_link_sva.sv ----
// aspm_link_sva: concurrent checks on the host-to-converter link
// assumes both ends share i_core_clk and the bench instantiates this beside the link
`timescale 1ns/1ps
module aspm_link_sva (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// link wires
	input wire logic frame_sel_n,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe,
	// converter status
	input wire logic o_in_shutdown,
	input wire logic o_tracking,
	input wire logic o_frame_done
);
	logic cs_q_ff; // select one cycle ago
	logic sclk_q_ff; // serial clock one cycle ago
	logic [4:0] falls_ff; // serial clock falls in this frame
	logic [4:0] rises_ff; // serial clock rises in this frame
	logic [4:0] nxt_falls;
	logic [4:0] nxt_rises;
	wire frame_start = cs_q_ff & ~frame_sel_n; // select fall seen
	wire sclk_fall = sclk_q_ff & ~sclk & ~frame_sel_n;
	wire sclk_rise = ~sclk_q_ff & sclk & ~frame_sel_n;
	assign nxt_falls = frame_start ? 5'h00 : (sclk_fall ? falls_ff + 5'h01 : falls_ff);
	assign nxt_rises = frame_start ? 5'h00 : (sclk_rise ? rises_ff + 5'h01 : rises_ff);
	// edge counters, cleared at each frame start
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cs_q_ff <= 1'b1;
			sclk_q_ff <= 1'b1;
			falls_ff <= 5'h00;
			rises_ff <= 5'h00;
		end else begin
			cs_q_ff <= frame_sel_n;
			sclk_q_ff <= sclk;
			falls_ff <= nxt_falls;
			rises_ff <= nxt_rises;
		end
	end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);
	oe_on_fall_a: assert property ($fell(frame_sel_n) |-> ##[2:5] sdo_oe)
		else $error("data line not driven after select fall");
	float_on_rise_a: assert property ($rose(frame_sel_n) |-> ##[1:5] !sdo_oe)
		else $error("data line still driven after select rise");
	float_after_word_a: assert property ($rose(falls_ff == 5'h10) |-> ##[1:5] !sdo_oe)
		else $error("data line still driven after word end");
	idle_float_a: assert property (frame_sel_n && $past(frame_sel_n, 6) |-> !sdo_oe)
		else $error("data line driven between frames");
	lead_zero_a: assert property (sdo_oe && falls_ff <= 5'h03 |-> !sdo)
		else $error("leading bit not zero");
	normal_on_fall_a: assert property ($fell(frame_sel_n) |-> ##[2:6] !o_in_shutdown)
		else $error("no normal mode after select fall");
	shdn_window_a: assert property ($rose(frame_sel_n) && falls_ff >= 5'h02
		&& falls_ff < 5'h0A |-> ##[2:6] o_in_shutdown)
		else $error("no shutdown after early select rise");
	shdn_hold_a: assert property (o_in_shutdown && frame_sel_n
		&& $past(frame_sel_n, 5) |=> o_in_shutdown)
		else $error("shutdown left without select fall");
	hold_on_fall_a: assert property ($fell(frame_sel_n) |-> ##[2:5] !o_tracking)
		else $error("still tracking after select fall");
	track_rise_a: assert property ($rose(rises_ff == 5'h0D) |-> ##[1:5] o_tracking)
		else $error("no track after rise thirteen");
	done_count_a: assert property (o_frame_done |-> falls_ff == 5'h10)
		else $error("word end pulse at wrong count");
	// main scenarios
	shdn_c: cover property ($rose(o_in_shutdown));
	word_c: cover property (o_frame_done);
	frame_c: cover property ($fell(frame_sel_n));
endmodule : aspm_link_sva

// ---- sim/tb.sv ----
// tb: host and converter joined by one link, plus a bench-driven converter
// assumes the design files and aspm_cfg.svh are compiled first
`timescale 1ns/1ps
`include "aspm_cfg.svh"
module tb;
	logic i_core_clk = 1'b0; // core clock
	logic i_srst = 1'b1; // reset, held at start
	logic i_cmd_valid = 1'b0; // host command
	logic i_cmd_shdn = 1'b0;
	logic [`ASPM_RES_W-1:0] sample = 12'h000; // converter core result
	logic o_cmd_ready, o_result_valid, o_result_dummy;
	logic [`ASPM_RES_W-1:0] o_result;
	logic o_in_shutdown, o_tracking, o_powered_up, o_frame_done, o_frame_valid;
	logic b_shdn, b_trk, b_pu, b_done, b_valid; // bench-driven converter status
	logic [15:0] wire_word; // bits seen on the data line
	logic [4:0] wire_falls = 5'h00; // serial clock falls seen
	int fails = 0;
	int checks = 0;
	int b_words = 0; // completed words on the bench-driven converter
	aspm_link_if link ();
	aspm_link_if link_b ();
	always #5 i_core_clk = ~i_core_clk;
	initial begin
		link_b.frame_sel_n = 1'b1;
		link_b.sclk = 1'b1;
	end
	aspm_host u_aspm_host (.i_core_clk(i_core_clk), .i_srst(i_srst), .link(link.host),
		.i_cmd_valid(i_cmd_valid), .i_cmd_shdn(i_cmd_shdn), .o_cmd_ready(o_cmd_ready),
		.o_result(o_result), .o_result_valid(o_result_valid), .o_result_dummy(o_result_dummy));
	aspm_device u_aspm_device (.i_core_clk(i_core_clk), .i_srst(i_srst), .link(link.device),
		.i_sample(sample), .o_in_shutdown(o_in_shutdown), .o_tracking(o_tracking),
		.o_powered_up(o_powered_up), .o_frame_done(o_frame_done), .o_frame_valid(o_frame_valid));
	aspm_device u_aspm_device_b (.i_core_clk(i_core_clk), .i_srst(i_srst), .link(link_b.device),
		.i_sample(12'hA5C), .o_in_shutdown(b_shdn), .o_tracking(b_trk), .o_powered_up(b_pu),
		.o_frame_done(b_done), .o_frame_valid(b_valid));
	aspm_link_sva u_aspm_link_sva (.i_core_clk(i_core_clk), .i_srst(i_srst),
		.frame_sel_n(link.frame_sel_n), .sclk(link.sclk), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
		.o_in_shutdown(o_in_shutdown), .o_tracking(o_tracking), .o_frame_done(o_frame_done));
	// data line as a receiver sees it, one bit per fall
	always @(negedge link.sclk) begin
		if (link.frame_sel_n === 1'b0) begin
			if (wire_falls < 5'h10) wire_word = {wire_word[14:0], link.serial_result_out};
			wire_falls = wire_falls + 5'h01;
		end
	end
	// word end pulses, sampled away from the launching edge
	always @(negedge i_core_clk) begin
		if (b_done === 1'b1) b_words++;
	end
	task automatic step(input int k);
		repeat (k) @(posedge i_core_clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("counts: checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	// one host command, result and wire checked
	task automatic host_frame(input logic shdn, input logic [11:0] smp, input logic dmy);
		int n;
		logic got;
		sample = smp;
		wire_falls = 5'h00;
		got = 1'b0;
		n = 0;
		while (o_cmd_ready !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		if (o_cmd_ready !== 1'b1) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, o_cmd_ready, 1'b1);
			final_report;
		end
		i_cmd_valid = 1'b1;
		i_cmd_shdn = shdn;
		step(1);
		i_cmd_valid = 1'b0;
		n = 0;
		while (o_cmd_ready !== 1'b1 && n < 400) begin
			step(1);
			n++;
			if (o_result_valid === 1'b1) begin
				got = 1'b1;
				chk(o_result_dummy, dmy);
				if (!dmy) chk(o_result, smp);
			end
		end
		if (o_cmd_ready !== 1'b1) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, o_cmd_ready, 1'b1);
			final_report;
		end
		chk(got, !shdn);
		chk(wire_falls, shdn ? 5'h04 : 5'h14);
		if (!shdn) chk(wire_word, {4'h0, smp});
		if (!shdn) chk(o_frame_valid, !dmy);
		chk(o_in_shutdown, shdn);
		chk(o_powered_up, !shdn);
		chk(link.line_floating, 1'b1);
	endtask : host_frame
	// bench frame on the second converter: n falls, then select rise
	task automatic dev_frame(input int falls, input logic es, input logic [1:0] ep);
		link_b.frame_sel_n = 1'b0;
		step(4);
		for (int i = 0; i < falls; i++) begin
			link_b.sclk = 1'b0;
			step(4);
			link_b.sclk = 1'b1;
			step(4);
		end
		link_b.frame_sel_n = 1'b1;
		step(12); // longer than quiet_interval
		chk(b_shdn, es);
		if (ep != 2'h2) chk(b_pu, ep[0]);
		if (falls == 16) chk(b_valid, 1'b0);
		chk(link_b.line_floating, 1'b1);
		chk(b_trk, 1'b1);
	endtask : dev_frame
	logic h_shdn [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [11:0] h_smp [5] = '{12'h5A3, 12'hFFF, 12'h000, 12'h001, 12'h800};
	logic h_dmy [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	int d_falls [8] = '{1, 16, 1, 12, 10, 9, 11, 2};
	logic d_shdn [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [1:0] d_pu [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
	// main sequence
	initial begin
		repeat (12) @(posedge i_core_clk);
		#1;
		i_srst = 1'b0;
		chk(o_in_shutdown, 1'b1);
		chk(link.line_floating, 1'b1);
		for (int i = 0; i < 5; i++) begin
			host_frame(h_shdn[i], h_smp[i], h_dmy[i]);
			$display("host frame test %0d done", i);
		end
		for (int i = 0; i < 8; i++) begin
			dev_frame(d_falls[i], d_shdn[i], d_pu[i]);
			$display("select rise test after %0d falls done", d_falls[i]);
		end
		chk(16'(b_words), 16'h0001);
		final_report;
	end
endmodule : tb
